// ==== hpp_consts.svh ====
// Selector codes, offsets, field positions and timing of the host port
`ifndef HPP_CONSTS_SVH
`define HPP_CONSTS_SVH
`define HPP_SEL_CTRL      2'b00
`define HPP_SEL_DATA_INC  2'b01
`define HPP_SEL_ADDR      2'b10
`define HPP_SEL_DATA      2'b11
`define HPP_RAM_FIRST     16'h1000
`define HPP_RAM_LAST      16'h17ff
`define HPP_CLK_NS        8
`define HPP_HOM_BYTE_NS   50
`define HPP_SAM_BYTE_CLKS 5
`define HPP_HOM_BYTE_CLKS ((`HPP_HOM_BYTE_NS) / (`HPP_CLK_NS))
`define HPP_HC_CINT       0
`define HPP_HC_HACK       1
`define HPP_HC_XSEL       2
`define HPP_REG_CTRL      4'h0
`define HPP_REG_ADDR      4'h4
`define HPP_CTRL_HOM      0
`define HPP_CTRL_HOST_INTERRUPT_N     1
`define HPP_CTRL_CINT     2
`endif

// ==== hpp_host_model.sv ====
// Host processor model that drives the 8-bit parallel port
`timescale 1ns/10ps
`default_nettype none
module hpp_host_model (
    input  wire logic       core_clk,
    input  wire logic       host_ready,
    input  wire logic [7:0] hostDataOut,
    input  wire logic       hostDataOe_n,
    output logic      [7:0] hostDataIn,
    output logic            byte_half_select,
    output logic            access_select_1,
    output logic            access_select_0,
    output logic            data_strobe_1_n,
    output logic            data_strobe_2_n,
    output logic            readNotWrite,
    output logic      [7:0] lowRun,
    output logic            oeAtRead
);
    logic [7:0] lowCnt;
    initial
    begin
        hostDataIn = 8'h00;
        byte_half_select = 1'h0;
        {access_select_1, access_select_0} = 2'h0;
        {data_strobe_1_n, data_strobe_2_n} = 2'h3;
        readNotWrite = 1'h1;
    end
    // Length of the last not-ready stretch, used for rate checks
    always @(posedge core_clk)
    begin
        lowCnt <= host_ready ? 8'h00 : lowCnt + 8'h01;
        if (host_ready && lowCnt != 8'h00)
            lowRun <= lowCnt;
    end
    // One byte; lower halves use the second strobe so both get exercised
    task automatic xfer(input logic [1:0] sel, input logic half,
                        input logic rnw, input logic [7:0] wr,
                        output logic [7:0] rd);
        // No limit here; the bench watchdog ends a hang
        do @(posedge core_clk); while (host_ready !== 1'h1);
        {access_select_1, access_select_0} <= sel;
        byte_half_select <= half;
        readNotWrite <= rnw;
        hostDataIn <= wr;
        if (half)
            data_strobe_2_n <= 1'h0;
        else
            data_strobe_1_n <= 1'h0;
        repeat (3) @(posedge core_clk);
        rd = hostDataOut;
        oeAtRead = hostDataOe_n;
        {data_strobe_1_n, data_strobe_2_n} <= 2'h3;
        // Released bus no longer shows the old byte
        hostDataIn <= ~wr;
    endtask
endmodule
`default_nettype wire

// ==== hpp_host_port.sv ====
// 8-bit parallel host port with dual access RAM and extended memory path
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`include "hpp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module hpp_host_port #(
    parameter int ENHANCED = 1,
    parameter int RAM_AW   = 11
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              cke,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [7:0]        hostDataIn,
    output logic      [7:0]        hostDataOut,
    output logic                   hostDataOe_n,
    input  wire logic              byte_half_select,
    input  wire logic              access_select_1,
    input  wire logic              access_select_0,
    input  wire logic              data_strobe_1_n,
    input  wire logic              data_strobe_2_n,
    input  wire logic              readNotWrite,
    input  wire logic              addrStrobe_n,
    output logic                   host_ready,
    output logic                   host_interrupt_n,
    input  wire logic              coreReq,
    input  wire logic              coreWe,
    input  wire logic [RAM_AW-1:0] coreAddr,
    input  wire logic [15:0]       coreWdata,
    output logic      [15:0]       coreRdata,
    output logic                   coreStall,
    output logic                   coreIrq,
    input  wire logic              coreInReset,
    input  wire logic              coreClkStop,
    output logic                   portQuiet,
    output logic                   extReq,
    output logic                   extWe,
    output hpp_pkg::hpp_addr_t     extAddr,
    output logic      [15:0]       extWdata,
    input  wire logic              extAck,
    input  wire logic [15:0]       extRdata,
    input  wire logic [5:0]        dmaChanReq,
    output logic      [5:0]        dmaChanGnt
);
    import hpp_pkg::*;

    localparam int SAM_CLKS = `HPP_SAM_BYTE_CLKS;
    localparam int HOM_CLKS = (`HPP_HOM_BYTE_CLKS < 1) ? 1
                                                       : `HPP_HOM_BYTE_CLKS;

    if (ENHANCED < 0 || ENHANCED > 1 || RAM_AW < 1 || RAM_AW > 16)
    begin : g_bad_param
        $error("hpp_host_port: unsupported parameter values");
    end

    function automatic logic [7:0] pickByte(input logic [15:0] w,
                                            input logic        low);
        pickByte = low ? w[7:0] : w[15:8];
    endfunction

    function automatic logic isRam(input hpp_addr_t a);
        isRam = (a[22:16] == 7'h0) && (a[15:0] >= `HPP_RAM_FIRST)
                && (a[15:0] <= `HPP_RAM_LAST);
    endfunction

    hpp_mem_st_t         st_q, st_d;
    hpp_addr_t           addr_q, addr_d;
    logic [15:0]         rdBuf_q, rdBuf_d;
    logic [15:0]         wrWord_q, wrWord_d;
    logic [15:0]         coreRd_q, coreRd_d;
    logic [7:0]          wrHi_q, wrHi_d;
    logic [7:0]          dout_q, dout_d;
    logic [3:0]          cnt_q, cnt_d;
    logic [1:0]          asSel_q, asSel_d;
    logic [31:0]         wbDat_q, wbDat_d;
    logic                oeN_q, oeN_d;
    logic                xsel_q, xsel_d;
    logic                coreInt_q, coreInt_d;
    logic                hostInt_q, hostInt_d;
    logic                hom_q, hom_d;
    logic                incAfter_q, incAfter_d;
    logic                opWr_q, opWr_d;
    logic                strobe_q, strobe_d;
    logic                asUsed_q, asUsed_d;
    logic                asBhs_q, asBhs_d;
    logic                asRd_q, asRd_d;
    logic                wbAck_q, wbAck_d;
    logic [15:0]         ram [2**RAM_AW];
    logic                ramWe;
    logic [RAM_AW-1:0]   ramIdx;
    logic                coreWr;
    logic                strobeNow;
    logic                strobeStart;
    logic [1:0]          selEff;
    logic                bhsEff;
    logic                rdEff;
    logic                hostOnly;
    logic                hostWordWr;
    logic                wbAcc;
    logic [15:0]         hostWord;
    logic [15:0]         ctlWord;
    logic                startOp;
    logic                writeOp;
    logic                hostCintSet;
    logic                hostAck;
    logic                wbHintSet;
    logic                wbCintClr;

    // Either strobe low alone marks a cycle; suits single or split strobes
    assign strobeNow   = data_strobe_1_n ^ data_strobe_2_n;
    assign strobeStart = strobeNow && !strobe_q;
    // Multiplexed hosts latch controls on the address strobe
    assign selEff = asUsed_q ? asSel_q
                             : {access_select_1, access_select_0};
    assign bhsEff = asUsed_q ? asBhs_q : byte_half_select;
    assign rdEff  = asUsed_q ? asRd_q : readNotWrite;
    assign hostOnly   = hom_q || coreInReset || coreClkStop;
    assign hostWordWr = strobeStart && !rdEff && bhsEff;
    assign hostWord   = {wrHi_q, hostDataIn};
    assign wbAcc      = wb_cyc_i && wb_stb_i && !wbAck_q;

    always_comb
    begin
        st_d = st_q;
        addr_d = addr_q;
        rdBuf_d = rdBuf_q;
        wrWord_d = wrWord_q;
        wrHi_d = wrHi_q;
        dout_d = dout_q;
        xsel_d = xsel_q;
        hom_d = hom_q;
        incAfter_d = incAfter_q;
        opWr_d = opWr_q;
        asUsed_d = asUsed_q;
        asSel_d = asSel_q;
        asBhs_d = asBhs_q;
        asRd_d = asRd_q;
        strobe_d = strobeNow;
        cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
        oeN_d = !(strobeNow && rdEff);
        ramWe = 1'b0;
        ramIdx = addr_q[RAM_AW-1:0];
        startOp = 1'b0;
        writeOp = 1'b0;
        hostCintSet = 1'b0;
        hostAck = 1'b0;
        wbHintSet = 1'b0;
        wbCintClr = 1'b0;
        wbAck_d = wbAcc;
        wbDat_d = '0;
        coreRd_d = coreRd_q;
        ctlWord = '0;
        ctlWord[`HPP_HC_CINT] = coreInt_q;
        ctlWord[`HPP_HC_HACK] = hostInt_q;
        ctlWord[`HPP_HC_XSEL] = xsel_q;
        if (!addrStrobe_n)
        begin
            asUsed_d = 1'b1;
            asSel_d = {access_select_1, access_select_0};
            asBhs_d = byte_half_select;
            asRd_d = readNotWrite;
        end
        // Memory engine; one RAM or external cycle per host operation
        unique case (st_q)
            MEM_IDLE: st_d = st_q;
            MEM_RAM:
            begin
                ramWe = opWr_q;
                if (!opWr_q)
                    rdBuf_d = ram[ramIdx];
                if (incAfter_q)
                    addr_d = addr_q + 23'h1;
                st_d = MEM_IDLE;
            end
            MEM_EXT:
            begin
                if (extAck)
                begin
                    if (!opWr_q)
                        rdBuf_d = extRdata;
                    if (incAfter_q)
                        addr_d = addr_q + 23'h1;
                    st_d = MEM_IDLE;
                end
            end
            default: st_d = MEM_IDLE;
        endcase
        if (strobeStart)
        begin
            cnt_d = hostOnly ? 4'(HOM_CLKS - 1)
                             : 4'(SAM_CLKS - 1);
            if (rdEff)
            begin
                unique case (selEff)
                    `HPP_SEL_CTRL: dout_d = pickByte(ctlWord, bhsEff);
                    `HPP_SEL_ADDR:
                        dout_d = pickByte(xsel_q ? {9'h0, addr_q[22:16]}
                                                 : addr_q[15:0], bhsEff);
                    `HPP_SEL_DATA_INC,
                    `HPP_SEL_DATA: dout_d = pickByte(rdBuf_q, bhsEff);
                endcase
                if (bhsEff && selEff == `HPP_SEL_DATA_INC)
                begin
                    addr_d = addr_q + 23'h1;
                    startOp = 1'b1;
                end
            end
            else if (!bhsEff)
                wrHi_d = hostDataIn;
            else
            begin
                unique case (selEff)
                    `HPP_SEL_CTRL:
                    begin
                        hostCintSet = hostWord[`HPP_HC_CINT];
                        hostAck = hostWord[`HPP_HC_HACK];
                        xsel_d = hostWord[`HPP_HC_XSEL];
                        startOp = 1'b1;
                    end
                    `HPP_SEL_ADDR:
                    begin
                        // Host sets the upper part first, then the lower
                        if (ENHANCED == 1 && xsel_q)
                            addr_d[22:16] = hostWord[6:0];
                        else
                            addr_d[15:0] = hostWord;
                        startOp = 1'b1;
                    end
                    `HPP_SEL_DATA_INC,
                    `HPP_SEL_DATA:
                    begin
                        wrWord_d = hostWord;
                        writeOp = 1'b1;
                    end
                endcase
            end
            if (startOp || writeOp)
            begin
                // Basic port folds every address into the local RAM
                st_d = (ENHANCED == 1 && !isRam(addr_d)) ? MEM_EXT
                                                         : MEM_RAM;
                opWr_d = writeOp;
                incAfter_d = writeOp && selEff == `HPP_SEL_DATA_INC;
            end
        end
        if (wbAcc)
        begin
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == `HPP_REG_CTRL)
            begin
                hom_d = wb_dat_i[`HPP_CTRL_HOM];
                wbHintSet = wb_dat_i[`HPP_CTRL_HOST_INTERRUPT_N];
                wbCintClr = wb_dat_i[`HPP_CTRL_CINT];
            end
            else if (!wb_we_i && wb_adr_i == `HPP_REG_CTRL)
            begin
                wbDat_d[`HPP_CTRL_HOM] = hom_q;
                wbDat_d[`HPP_CTRL_HOST_INTERRUPT_N] = hostInt_q;
                wbDat_d[`HPP_CTRL_CINT] = coreInt_q;
            end
            else if (!wb_we_i && wb_adr_i == `HPP_REG_ADDR)
                wbDat_d = {9'h0, addr_q};
        end
        // Set wins over a clear arriving in the same cycle
        coreInt_d = (coreInt_q && !wbCintClr) || hostCintSet;
        hostInt_d = (hostInt_q && !hostAck) || wbHintSet;
        if (coreReq && !coreWe && !coreStall)
            coreRd_d = ram[coreAddr];
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st_q <= MEM_IDLE;
            addr_q <= '0;
            rdBuf_q <= '0;
            wrWord_q <= '0;
            wrHi_q <= '0;
            dout_q <= '0;
            cnt_q <= '0;
            oeN_q <= '1;
            xsel_q <= '0;
            coreInt_q <= '0;
            hostInt_q <= '0;
            hom_q <= '0;
            incAfter_q <= '0;
            opWr_q <= '0;
            strobe_q <= '0;
            asUsed_q <= '0;
            asSel_q <= '0;
            asBhs_q <= '0;
            asRd_q <= '0;
            wbAck_q <= '0;
            wbDat_q <= '0;
            coreRd_q <= '0;
        end
        else if (cke)
        begin
            st_q <= st_d;
            addr_q <= addr_d;
            rdBuf_q <= rdBuf_d;
            wrWord_q <= wrWord_d;
            wrHi_q <= wrHi_d;
            dout_q <= dout_d;
            cnt_q <= cnt_d;
            oeN_q <= oeN_d;
            xsel_q <= xsel_d;
            coreInt_q <= coreInt_d;
            hostInt_q <= hostInt_d;
            hom_q <= hom_d;
            incAfter_q <= incAfter_d;
            opWr_q <= opWr_d;
            strobe_q <= strobe_d;
            asUsed_q <= asUsed_d;
            asSel_q <= asSel_d;
            asBhs_q <= asBhs_d;
            asRd_q <= asRd_d;
            wbAck_q <= wbAck_d;
            wbDat_q <= wbDat_d;
            coreRd_q <= coreRd_d;
        end
    end

    // Shared RAM; the host cycle pre-empts the core write
    assign coreWr = coreReq && coreWe && !coreStall;
    always_ff @(posedge core_clk)
    begin
        if (cke && ramWe)
            ram[ramIdx] <= wrWord_q;
        else if (cke && coreWr)
            ram[coreAddr] <= coreWdata;
    end

    assign coreStall = coreReq && (st_q == MEM_RAM || hostOnly);
    // Host path has no core gating, so it lives through core idle
    assign host_ready = (cnt_q == 4'h0) && (st_q == MEM_IDLE);
    assign portQuiet = host_ready && (dmaChanReq == 6'h0);
    assign extReq = (st_q == MEM_EXT);
    assign extWe = opWr_q;
    assign extAddr = addr_q;
    assign extWdata = wrWord_q;
    // Fixed lowest-channel pick; channels only see the leftover slots
    assign dmaChanGnt = extReq ? 6'h0
                               : dmaChanReq & (~dmaChanReq + 6'h1);
    assign host_interrupt_n = !hostInt_q;
    assign coreIrq = coreInt_q;
    assign coreRdata = coreRd_q;
    assign hostDataOut = dout_q;
    assign hostDataOe_n = oeN_q;
    assign wb_dat_o = wbDat_q;
    assign wb_ack_o = wbAck_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst || !cke);

    a_host_wins_ram: assert property (
        (st_q == MEM_RAM && opWr_q) |-> !coreWr
        ##1 ram[$past(ramIdx)] == $past(wrWord_q))
        else $error("host write lost in shared RAM");
    a_stall_single: assert property (
        (coreStall && !hostOnly) |=> !coreStall)
        else $error("core stalled more than one cycle");
    a_ready_busy: assert property (
        strobeStart |=> !host_ready)
        else $error("ready high right after strobe");
    a_sam_cadence: assert property (
        (strobeStart && !hostOnly && rdEff && selEff == `HPP_SEL_CTRL)
        |=> !host_ready [*4] ##1 host_ready)
        else $error("shared mode byte period wrong");
    a_hom_cadence: assert property (
        (strobeStart && hostOnly && rdEff && selEff == `HPP_SEL_CTRL)
        |=> !host_ready [*5] ##1 host_ready)
        else $error("host-only byte period wrong");
    a_host_interrupt_n_held: assert property (
        (!host_interrupt_n && !(hostWordWr && selEff == `HPP_SEL_CTRL
            && hostDataIn[`HPP_HC_HACK])) |=> !host_interrupt_n)
        else $error("host interrupt dropped without ack");
    a_prefetch_go: assert property (
        (hostWordWr && selEff == `HPP_SEL_ADDR)
        |=> (st_q != MEM_IDLE) && !opWr_q)
        else $error("no prefetch after address write");
    a_inc_read: assert property (
        (strobeStart && rdEff && bhsEff && selEff == `HPP_SEL_DATA_INC)
        |=> addr_q == $past(addr_q) + 23'h1)
        else $error("address not incremented once");
    a_xsel_host_only: assert property (
        (wbAcc && !hostWordWr) |=> xsel_q == $past(xsel_q))
        else $error("core access changed extended select");
    a_dma_below: assert property (
        extReq |-> dmaChanGnt == 6'h0)
        else $error("DMA granted over host");
    a_core_irq: assert property (
        (hostWordWr && selEff == `HPP_SEL_CTRL
            && hostDataIn[`HPP_HC_CINT]) |=> coreIrq)
        else $error("core interrupt not raised");

    c_inc_word: cover property (
        strobeStart && rdEff && bhsEff && selEff == `HPP_SEL_DATA_INC);
    c_conflict: cover property (coreStall && st_q == MEM_RAM);
    c_ext_done: cover property (extReq && extAck);
endmodule
`default_nettype wire

// ==== hpp_pkg.sv ====
// Types shared by the host port
package hpp_pkg;
    typedef enum logic [1:0] {MEM_IDLE, MEM_RAM, MEM_EXT} hpp_mem_st_t;
    typedef logic [22:0] hpp_addr_t;
endpackage

// ==== tb_host_parallel_port_8bit.sv ====
// Self-checking bench for the 8-bit parallel host port
`include "hpp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_host_parallel_port_8bit;
    import hpp_pkg::*;
    logic        core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [7:0]  hostDataIn, hostDataOut, lowRun;
    logic        hostDataOe_n, byte_half_select, access_select_1;
    logic        access_select_0, data_strobe_1_n, data_strobe_2_n;
    logic        readNotWrite, host_ready, host_interrupt_n, coreReq;
    logic        coreInReset, coreStall, coreIrq, portQuiet, coreWe;
    logic        extReq, extWe, extAck, oeAtRead, coreClkStop;
    logic [10:0] coreAddr;
    logic [15:0] coreRdata, coreWdata, extWdata, extRdata, w;
    hpp_addr_t   extAddr;
    logic [5:0]  dmaChanReq, dmaChanGnt;
    logic [1:0]  extWait;
    logic [15:0] extMem [hpp_addr_t];
    int          badCount, comparisons, extCount, gntBad, stalls;

    hpp_host_port dut (.core_clk, .sys_rst, .cke(1'h1), .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .hostDataIn, .hostDataOut, .hostDataOe_n,
        .byte_half_select, .access_select_1, .access_select_0,
        .data_strobe_1_n, .data_strobe_2_n, .readNotWrite,
        .addrStrobe_n(1'h1), .host_ready, .host_interrupt_n, .coreReq,
        .coreWe, .coreAddr, .coreWdata, .coreRdata,
        .coreStall, .coreIrq, .coreInReset, .coreClkStop, .portQuiet,
        .extReq, .extWe, .extAddr, .extWdata, .extAck, .extRdata,
        .dmaChanReq, .dmaChanGnt);
    hpp_host_model host (.core_clk, .host_ready, .hostDataOut, .hostDataIn,
        .byte_half_select, .access_select_1, .access_select_0,
        .data_strobe_1_n, .data_strobe_2_n, .readNotWrite, .lowRun,
        .hostDataOe_n, .oeAtRead);

    initial
    begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end
    // Memory behind the extended path answers after three cycles
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            {extAck, extWait, extRdata} <= 19'h0;
            {extCount, gntBad, stalls} <= 96'h0;
        end
        else
        begin
            extAck <= 1'h0;
            extWait <= 2'h0;
            stalls <= stalls + int'(coreReq && coreStall);
            if (extReq === 1'h1 && !extAck)
            begin
                extWait <= extWait + 2'h1;
                if (dmaChanGnt !== 6'h00)
                    gntBad <= 1;
                if (extWait == 2'h2)
                begin
                    extAck <= 1'h1;
                    extCount <= extCount + 1;
                    if (extWe)
                        extMem[extAddr] = extWdata;
                    if (extMem.exists(extAddr))
                        extRdata <= extMem[extAddr];
                    else
                        extRdata <= ~extAddr[15:0];
                end
            end
            else
                extRdata <= ~extRdata;
        end
    end
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            badCount++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge core_clk); while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_sel_i <= 4'h0;
        @(posedge core_clk);
    endtask
    task automatic hw(input logic [1:0] s, input logic [15:0] v);
        logic [7:0] b;
        host.xfer(s, 1'h0, 1'h0, v[15:8], b);
        host.xfer(s, 1'h1, 1'h0, v[7:0], b);
    endtask
    task automatic hr(input logic [1:0] s);
        host.xfer(s, 1'h0, 1'h1, 8'h00, w[15:8]);
        host.xfer(s, 1'h1, 1'h1, 8'h00, w[7:0]);
    endtask
    // Upper part first with the select bit set, then the lower part
    task automatic load(input hpp_addr_t a);
        hw(`HPP_SEL_CTRL, 16'h0004);
        hw(`HPP_SEL_ADDR, {9'h000, a[22:16]});
        hw(`HPP_SEL_CTRL, 16'h0000);
        hw(`HPP_SEL_ADDR, a[15:0]);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        badCount++;
        close_out();
    end
    initial
    begin
        int c;
        {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
        {coreReq, coreInReset, coreClkStop, coreWe, coreAddr} = 15'h0;
        coreWdata = 16'h0000;
        dmaChanReq = 6'h00;
        {badCount, comparisons} = 64'h0;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'h0;
        @(posedge core_clk);
        check("ready", host_ready, 1);
        check("host_interrupt_n", host_interrupt_n, 1);
        check("oe", hostDataOe_n, 1);
        dmaChanReq <= 6'h0a;
        repeat (2) @(posedge core_clk);
        check("gnt", dmaChanGnt, 6'h02);
        check("quiet", portQuiet, 0);
        hw(`HPP_SEL_CTRL, 16'h0001);
        repeat (2) @(posedge core_clk);
        check("core irq", coreIrq, 1);
        wb(1'h1, `HPP_REG_CTRL, 32'h4);
        check("core irq clr", coreIrq, 0);
        wb(1'h1, `HPP_REG_CTRL, 32'h2);
        repeat (20) @(posedge core_clk);
        check("host_interrupt_n held", host_interrupt_n, 0);
        hw(`HPP_SEL_CTRL, 16'h0002);
        repeat (2) @(posedge core_clk);
        check("host_interrupt_n clr", host_interrupt_n, 1);
        host.xfer(`HPP_SEL_CTRL, 1'h0, 1'h1, 8'h00, w[7:0]);
        repeat (8) @(posedge core_clk);
        check("shared rate", lowRun, 8'h04);
        wb(1'h1, `HPP_REG_CTRL, 32'h1);
        host.xfer(`HPP_SEL_CTRL, 1'h0, 1'h1, 8'h00, w[7:0]);
        repeat (8) @(posedge core_clk);
        check("host only rate", lowRun, 8'h05);
        wb(1'h1, `HPP_REG_CTRL, 32'h0);
        c = extCount;
        load(23'h122000);
        repeat (8) @(posedge core_clk);
        check("prefetch", extCount - c, 4);
        wb(1'h0, `HPP_REG_ADDR, 32'h0);
        check("addr", rd, 32'h00122000);
        hw(`HPP_SEL_DATA_INC, 16'h1234);
        hw(`HPP_SEL_DATA_INC, 16'h5678);
        repeat (8) @(posedge core_clk);
        check("mem0", extMem[23'h122000], 16'h1234);
        check("mem1", extMem[23'h122001], 16'h5678);
        wb(1'h1, `HPP_REG_ADDR, 32'h0);
        wb(1'h0, `HPP_REG_ADDR, 32'h0);
        check("addr inc", rd, 32'h00122002);
        hw(`HPP_SEL_ADDR, 16'h2000);
        hr(`HPP_SEL_DATA_INC);
        check("rd0", w, 16'h1234);
        check("oe read", oeAtRead, 0);
        hr(`HPP_SEL_DATA_INC);
        check("rd1", w, 16'h5678);
        wb(1'h0, 4'h8, 32'h0);
        check("unmapped", rd, 32'h0);
        check("gnt busy", gntBad, 0);
        load(23'h001000);
        repeat (8) @(posedge core_clk);
        coreReq <= 1'h1;
        c = stalls;
        hw(`HPP_SEL_DATA, 16'hbeef);
        repeat (4) @(posedge core_clk);
        check("stall once", stalls - c, 1);
        check("core rd", coreRdata, 16'hbeef);
        coreInReset <= 1'h1;
        repeat (2) @(posedge core_clk);
        check("stall", coreStall, 1);
        hw(`HPP_SEL_ADDR, 16'h1000);
        hr(`HPP_SEL_DATA);
        check("reset rd", w, 16'hbeef);
        {coreInReset, coreClkStop} <= 2'h1;
        repeat (2) @(posedge core_clk);
        check("clk stop stall", coreStall, 1);
        {coreClkStop, coreWe, coreWdata} <= {2'h1, 16'h5a5a};
        @(posedge core_clk);
        coreWe <= 1'h0;
        hw(`HPP_SEL_ADDR, 16'h1000);
        hr(`HPP_SEL_DATA);
        check("core wr", w, 16'h5a5a);
        {coreInReset, coreReq, dmaChanReq} <= 8'h0;
        repeat (4) @(posedge core_clk);
        check("quiet idle", portQuiet, 1);
        close_out();
    end
endmodule
`default_nettype wire
